// File: lcap_cmd_dec.sv
// lcap_cmd_dec: classifies the command field of the control register.
// assumes the command and state fields come straight from flip-flops.
module lcap_cmd_dec (
  // command fields
  input wire logic [4:0] cmd_in,
  input wire logic [1:0] state_field_in,
  // classification
  output logic valid_out,
  output logic loads_data_out,
  output logic [1:0] state_out
);
  import lcap_pkg::*;

  lcap_kind_t kind;
  wire tag_write;

  // tag writes carry the line state inside the command word
  assign kind = lcap_decode(cmd_in);
  assign tag_write = (kind == K_TAG_DATA_WRITE) ||
                     (kind == K_TAG_ONLY_WRITE); // RQ7
  assign valid_out = (kind != K_NONE);
  assign loads_data_out = (kind == K_READ_LRU) ||
                          (kind == K_TAG_DATA_READ) ||
                          (kind == K_INT_REG_READ); // RQ5 RQ6
  assign state_out = tag_write ? cmd_in[1:0] : state_field_in; // RQ8
endmodule

// File: lcap_l2_model.sv
// lcap_l2_model: behavioural second-level cache that answers held requests.
// assumes each request stays up until its done pulse has been sampled.
module lcap_l2_model #(
  parameter logic [7:0] ECC_V = 8'ha5,
  parameter logic [255:0] RD_V = 256'h0
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // request from the access port, delay_in from the bench
  input wire logic req_in,
  input wire logic [1:0] state_in,
  input wire logic [1:0] way_in,
  input wire logic [3:0] delay_in,
  // answer to the access port
  output logic done_out,
  output logic hit_out,
  output logic [1:0] state_out,
  output logic [1:0] way_out,
  output logic [7:0] ecc_out,
  output logic [255:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r = 4'h0;
  logic done_r = 1'b0;

  // one done pulse after delay_in plus one held cycles; slow or prompt per test
  always @(posedge ref_clk_in) begin
    if (reset_in || done_r) begin
      done_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (req_in) begin
      if (cnt_r == delay_in) done_r <= 1'b1;
      else cnt_r <= cnt_r + 4'h1;
    end
  end

  // response valid only in the done cycle; inverted otherwise so a
  // late sample never matches by luck
  assign done_out = done_r;
  // hit on even ways only, so a stuck hit bit shows up
  assign hit_out = done_r ? ~way_in[0] : way_in[0];
  assign state_out = done_r ? state_in : ~state_in;
  assign way_out = done_r ? way_in : ~way_in;
  assign ecc_out = done_r ? ECC_V : ~ECC_V;
  assign rdata_out = done_r ? RD_V : ~RD_V;
endmodule

// File: lcap_pkg.sv
// lcap_pkg: register map, field layout and command codes of the
// l2 configuration access port.
// assumes one core clock and a plain strobe register port.
package lcap_pkg;
  // register port and line geometry
  localparam int LCAP_AW = 12;
  localparam int LCAP_DW = 64;
  localparam int LCAP_CHUNKS = 4;
  localparam int LCAP_ECC_W = 8;
  // register indices, as printed
  localparam logic [11:0] OFF_LINE_CHUNK_DATA = 12'h088;
  localparam logic [11:0] OFF_ACCESS_ADDRESS = 12'h116;
  localparam logic [11:0] OFF_ACCESS_ECC_BYTE = 12'h118;
  localparam logic [11:0] OFF_COMMAND_CONTROL = 12'h119;
  localparam logic [11:0] OFF_ACCESS_TRIGGER = 12'h11a;
  localparam logic [11:0] OFF_ACCESS_IN_PROGRESS = 12'h11b;
  // field positions
  localparam int ADDR_LO = 3;
  localparam int ADDR_HI = 31;
  localparam int CMD_LO = 0;
  localparam int STATE_TO_LO = 5;
  localparam int WAY_TO_LO = 10;
  localparam int WAY_FROM_LO = 12;
  localparam int STATE_FROM_LO = 14;
  localparam int HIT_BIT = 16;
  localparam int USER_ECC_BIT = 18;
  localparam int BUSY_BIT = 0;
  // reset values
  localparam logic [63:0] ADDR_RST = 64'h0;
  localparam logic [7:0] ECC_RST = 8'h0;
  localparam logic [63:0] CTL_RST = 64'h0;
  localparam logic [63:0] CHUNK_RST = 64'h0;
  // command codes
  localparam logic [4:0] CMD_DATA_READ_LRU_UPDATE = 5'h0c;
  localparam logic [4:0] CMD_TAG_AND_DATA_READ = 5'h0f;
  localparam logic [4:0] CMD_TAG_INQUIRE = 5'h02;
  localparam logic [4:0] CMD_L2_INTERNAL_REG_READ = 5'h07;
  localparam logic [4:0] CMD_L2_INTERNAL_REG_WRITE = 5'h03;
  localparam logic [2:0] PFX_TAG_AND_DATA_WRITE_A = 3'h2;
  localparam logic [2:0] PFX_TAG_AND_DATA_WRITE_B = 3'h7;
  localparam logic [2:0] PFX_TAG_ONLY_WRITE = 3'h4;
  // line state codes
  localparam logic [1:0] ST_MODIFIED = 2'h3;
  localparam logic [1:0] ST_EXCLUSIVE = 2'h2;
  localparam logic [1:0] ST_SHARED = 2'h1;
  localparam logic [1:0] ST_INVALID = 2'h0;

  typedef enum logic [2:0] {
    K_NONE, K_READ_LRU, K_TAG_DATA_READ, K_TAG_INQUIRE,
    K_INT_REG_READ, K_INT_REG_WRITE, K_TAG_DATA_WRITE, K_TAG_ONLY_WRITE
  } lcap_kind_t;

  // command word to kind; shared by decoder and checks
  function automatic lcap_kind_t lcap_decode(input logic [4:0] c);
    lcap_kind_t k;
    k = K_NONE;
    if (c == CMD_DATA_READ_LRU_UPDATE) k = K_READ_LRU;
    else if (c == CMD_TAG_AND_DATA_READ) k = K_TAG_DATA_READ;
    else if (c == CMD_TAG_INQUIRE) k = K_TAG_INQUIRE;
    else if (c == CMD_L2_INTERNAL_REG_READ) k = K_INT_REG_READ;
    else if (c == CMD_L2_INTERNAL_REG_WRITE) k = K_INT_REG_WRITE;
    else if (c[4:2] == PFX_TAG_AND_DATA_WRITE_A) k = K_TAG_DATA_WRITE;
    else if (c[4:2] == PFX_TAG_AND_DATA_WRITE_B) k = K_TAG_DATA_WRITE;
    else if (c[4:2] == PFX_TAG_ONLY_WRITE) k = K_TAG_ONLY_WRITE;
    return k;
  endfunction
endpackage

// File: lcap_seq.sv
// lcap_seq: one outstanding l2 command, request held until done.
// assumes done_in is a one-cycle pulse from the cache.
module lcap_seq (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // control
  input wire logic start_in,
  input wire logic done_in,
  // status
  output logic busy_out,
  output logic finish_out
);
  import lcap_pkg::*;

  typedef enum logic [1:0] {S_IDLE = 2'b01, S_WAIT = 2'b10} lcap_seq_t;
  lcap_seq_t state_r, state_nxt;

  // a done pulse seen while idle is stray and ignored
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: if (start_in) state_nxt = S_WAIT;
      S_WAIT: if (done_in) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) state_r <= S_IDLE;
    else state_r <= state_nxt;
  end

  assign busy_out = (state_r == S_WAIT); // RQ12
  assign finish_out = (state_r == S_WAIT) && done_in;
endmodule

// File: lcap_tb.sv
// tb: self-checking bench for lcap_top with a behavioural cache model.
// assumes the register port answers reads one cycle after the strobe.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lcap_pkg::*;
  localparam logic [7:0] ECC_V = 8'ha5;
  localparam logic [255:0] RD_V = {64'hd3, 64'hd2, 64'hd1, 64'hd0};
  logic ref_clk;
  logic reset;
  logic [11:0] addr;
  logic [63:0] wdata;
  logic [63:0] rdata;
  logic wr_s;
  logic rd_s;
  logic l2_req;
  logic [4:0] l2_cmd;
  logic [31:3] l2_addr;
  logic [1:0] l2_st;
  logic [1:0] l2_way;
  logic l2_uecc;
  logic [7:0] l2_ecc;
  logic [255:0] l2_wdata;
  logic done;
  logic hit;
  logic [1:0] st_back;
  logic [1:0] way_back;
  logic [7:0] ecc_back;
  logic [255:0] rd_back;
  logic [3:0] dly;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  lcap_top DUT (.ref_clk_in(ref_clk), .reset_in(reset),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_rdata_out(rdata), .l2_req_out(l2_req),
    .l2_cmd_out(l2_cmd), .l2_addr_out(l2_addr), .l2_state_out(l2_st),
    .l2_way_out(l2_way), .l2_user_ecc_out(l2_uecc), .l2_ecc_out(l2_ecc),
    .l2_wdata_out(l2_wdata), .l2_done_in(done), .l2_hit_in(hit),
    .l2_state_in(st_back), .l2_way_in(way_back), .l2_ecc_in(ecc_back),
    .l2_rdata_in(rd_back));

  lcap_l2_model #(.ECC_V(ECC_V), .RD_V(RD_V)) cache (.ref_clk_in(ref_clk),
    .reset_in(reset), .req_in(l2_req), .state_in(l2_st),
    .way_in(l2_way), .delay_in(dly), .done_out(done), .hit_out(hit),
    .state_out(st_back), .way_out(way_back), .ecc_out(ecc_back),
    .rdata_out(rd_back));

  // free-running core clock, 10 ns period
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge ref_clk);
    wr_s <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [11:0] a, input logic [63:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // field masks, read-only response bits, unmapped and write-only places
  task automatic t_regs();
    wr(OFF_ACCESS_ADDRESS, 64'hffff_fff8);
    rdchk(OFF_ACCESS_ADDRESS, 64'hffff_fff8);
    wr(OFF_ACCESS_ECC_BYTE, 64'h1ff);
    rdchk(OFF_ACCESS_ECC_BYTE, 64'hff);
    wr(OFF_COMMAND_CONTROL, '1);
    rdchk(OFF_COMMAND_CONTROL, 64'h4_0c7f);
    wr(OFF_LINE_CHUNK_DATA + 12'h2, 64'hfeed_f00d_0bad_cafe);
    rdchk(OFF_LINE_CHUNK_DATA + 12'h2, 64'hfeed_f00d_0bad_cafe);
    rdchk(12'h117, 64'h0);
    rdchk(OFF_ACCESS_TRIGGER, 64'h0);
    rdchk(OFF_ACCESS_IN_PROGRESS, 64'h0);
    wr(OFF_COMMAND_CONTROL, 64'h0);
  endtask

  // one full command: operands out, busy while held, response back
  task automatic t_cmd(input logic [4:0] c, input logic [1:0] s,
                       input logic [1:0] w, input logic [3:0] d);
    logic rdk;
    logic [1:0] es;
    rdk = (c == 5'h0c) || (c == 5'h0f) || (c == 5'h07);
    es = (c[4:2] == 3'h2 || c[4:2] == 3'h7 || c[4:2] == 3'h4) ? c[1:0] : s;
    dly <= d;
    wr(OFF_ACCESS_ECC_BYTE, 64'h3c);
    wr(OFF_LINE_CHUNK_DATA + 12'h1, 64'h1111);
    wr(OFF_ACCESS_ADDRESS, 64'h1234_5678);
    // user ecc option follows the answer speed, so both values are seen
    wr(OFF_COMMAND_CONTROL, {45'h0, d[0], 6'h0, w, 3'h0, s, c});
    wr(OFF_ACCESS_TRIGGER, 64'h0);
    #1;
    chk(l2_req, 1'b1);
    chk({l2_cmd, l2_st, l2_way, l2_uecc}, {c, es, w, d[0]});
    chk(l2_addr, 64'h1234_5678 >> 3);
    chk(l2_ecc, 8'h3c);
    chk(l2_wdata[127:64], 64'h1111);
    rdchk(OFF_ACCESS_IN_PROGRESS, 64'h1);
    for (int i = 0; i < 40 && l2_req === 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(l2_req, 1'b0);
    rdchk(OFF_ACCESS_IN_PROGRESS, 64'h0);
    // the model answers a hit only for even ways
    rdchk(OFF_COMMAND_CONTROL,
      {45'h0, d[0], 1'b0, ~w[0], es, w, w, 3'h0, s, c});
    rdchk(OFF_ACCESS_ECC_BYTE, rdk ? ECC_V : 8'h3c);
    rdchk(OFF_LINE_CHUNK_DATA + 12'h1, rdk ? RD_V[127:64] : 64'h1111);
  endtask

  // an unlisted code must never reach the cache
  task automatic t_bad();
    wr(OFF_COMMAND_CONTROL, 64'h0);
    wr(OFF_ACCESS_TRIGGER, 64'h0);
    #1;
    chk(l2_req, 1'b0);
    rdchk(OFF_ACCESS_IN_PROGRESS, 64'h0);
  endtask

  // every listed code, all states and ways, prompt and slow answers
  initial begin
    logic [4:0] cmds [9];
    cmds = '{5'h0c, 5'h0f, 5'h02, 5'h07, 5'h03, 5'h0b, 5'h1e, 5'h11, 5'h08};
    reset = 1'b1;
    addr = 12'h0;
    wdata = 64'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    dly = 4'h2;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    for (int i = 0; i < 9; i++) begin
      t_cmd(cmds[i], 2'(i % 4), 2'(3 - i % 4), (i % 2) ? 4'h9 : 4'h2);
    end
    t_bad();
    close_out();
  end
endmodule

// File: lcap_top.sv
// lcap_top: register front end that issues configuration commands to
// the second-level cache and collects its lookup response.
// assumes a single core clock, synchronous reset and a cache that
// answers each held request with one done pulse.
// Operation
// RQ1: address register keeps the line address in bits 31 to 3.
// RQ2: software writes address bits 2 to 0 as zero; upper bits reserved.
// RQ3: ecc register low byte goes out on writes, reloads on reads.
// RQ4: control register holds command and operands, then the response.
// RQ5: codes 01100, 01111, 00010 are lru read, tag read, inquire.
// RQ6: code 00111 reads and 00011 writes an internal cache register.
// RQ7: prefixes 010, 111 write tag and data; 100 writes tag only.
// RQ8: line state is 11 modified, 10 exclusive, 01 shared, 00 invalid.
// RQ9: way fields are two-bit binary, way 0 to way 3.
// RQ10: control carries a user ecc option plus hit, state, way.
// RQ11: trigger write starts the access; software writes zero there.
// RQ12: busy bit 0 is one while a command runs.
// RQ13: four 64-bit chunk registers go out on writes, load on reads.
// RQ14: software polls busy to zero before touching command registers.
module lcap_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [lcap_pkg::LCAP_AW-1:0] reg_addr_in,
  input wire logic [lcap_pkg::LCAP_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [lcap_pkg::LCAP_DW-1:0] reg_rdata_out,
  // request to the cache
  output logic l2_req_out,
  output logic [4:0] l2_cmd_out,
  output logic [lcap_pkg::ADDR_HI:lcap_pkg::ADDR_LO] l2_addr_out,
  output logic [1:0] l2_state_out,
  output logic [1:0] l2_way_out,
  output logic l2_user_ecc_out,
  output logic [lcap_pkg::LCAP_ECC_W-1:0] l2_ecc_out,
  output logic [lcap_pkg::LCAP_CHUNKS*64-1:0] l2_wdata_out,
  // answer from the cache
  input wire logic l2_done_in,
  input wire logic l2_hit_in,
  input wire logic [1:0] l2_state_in,
  input wire logic [1:0] l2_way_in,
  input wire logic [lcap_pkg::LCAP_ECC_W-1:0] l2_ecc_in,
  input wire logic [lcap_pkg::LCAP_CHUNKS*64-1:0] l2_rdata_in
);
  import lcap_pkg::*;

  localparam int NCH = LCAP_CHUNKS;

  // software visible state
  logic [ADDR_HI:ADDR_LO] addr_r;
  logic [LCAP_ECC_W-1:0] ecc_r;
  logic [4:0] cmd_r;
  logic [1:0] state_to_r;
  logic [1:0] way_to_r;
  logic user_ecc_r;
  logic hit_r;
  logic [1:0] state_from_r;
  logic [1:0] way_from_r;
  logic [63:0] chunk_r [NCH];
  logic [63:0] rdata_r;
  // command in flight
  logic loads_r;

  // decoded strobes
  wire hit_addr = reg_addr_in == OFF_ACCESS_ADDRESS;
  wire hit_ecc = reg_addr_in == OFF_ACCESS_ECC_BYTE;
  wire hit_ctl = reg_addr_in == OFF_COMMAND_CONTROL;
  wire hit_trig = reg_addr_in == OFF_ACCESS_TRIGGER;
  wire hit_busy = reg_addr_in == OFF_ACCESS_IN_PROGRESS;
  wire hit_chunk = reg_addr_in[11:2] == OFF_LINE_CHUNK_DATA[11:2];
  wire [1:0] chunk_sel = reg_addr_in[1:0];
  wire wr_addr = reg_wr_in && hit_addr;
  wire wr_ecc = reg_wr_in && hit_ecc;
  wire wr_ctl = reg_wr_in && hit_ctl;
  wire wr_chunk = reg_wr_in && hit_chunk;

  // command classification and sequencing
  logic cmd_valid;
  logic cmd_loads;
  logic [1:0] cmd_state;
  logic busy;
  logic finish;

  lcap_cmd_dec u_dec (
    .cmd_in(cmd_r),
    .state_field_in(state_to_r),
    .valid_out(cmd_valid),
    .loads_data_out(cmd_loads),
    .state_out(cmd_state)
  );

  // a trigger is taken only when idle and the command is known;
  // anything else is dropped silently, as a bus write cannot stall
  wire trig_ok = reg_wr_in && hit_trig && !busy && cmd_valid; // RQ11

  lcap_seq u_seq (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .start_in(trig_ok),
    .done_in(l2_done_in),
    .busy_out(busy),
    .finish_out(finish)
  );

  // response loads on finish; they win over a software write
  wire load_line = finish && loads_r;

  // address register; low three bits are never stored
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) addr_r <= ADDR_RST[ADDR_HI:ADDR_LO];
    else if (wr_addr) addr_r <= reg_wdata_in[ADDR_HI:ADDR_LO]; // RQ1
  end

  // ecc byte: software value, or read-back from the cache
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) ecc_r <= ECC_RST;
    else if (load_line) ecc_r <= l2_ecc_in; // RQ3
    else if (wr_ecc) ecc_r <= reg_wdata_in[LCAP_ECC_W-1:0]; // RQ3
  end

  // writable control fields: command, state, way, ecc option
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cmd_r <= CTL_RST[CMD_LO +: 5];
      state_to_r <= CTL_RST[STATE_TO_LO +: 2];
      way_to_r <= CTL_RST[WAY_TO_LO +: 2];
      user_ecc_r <= CTL_RST[USER_ECC_BIT];
    end else if (wr_ctl) begin
      cmd_r <= reg_wdata_in[CMD_LO +: 5]; // RQ4
      state_to_r <= reg_wdata_in[STATE_TO_LO +: 2]; // RQ8
      way_to_r <= reg_wdata_in[WAY_TO_LO +: 2]; // RQ9
      user_ecc_r <= reg_wdata_in[USER_ECC_BIT]; // RQ10
    end
  end

  // lookup response fields, read only to software
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      hit_r <= CTL_RST[HIT_BIT];
      state_from_r <= CTL_RST[STATE_FROM_LO +: 2];
      way_from_r <= CTL_RST[WAY_FROM_LO +: 2];
    end else if (finish) begin
      hit_r <= l2_hit_in; // RQ10
      state_from_r <= l2_state_in; // RQ4
      way_from_r <= l2_way_in; // RQ9
    end
  end

  // chunk registers, one per 64-bit slice of the line
  for (genvar i = 0; i < NCH; i++) begin : g_chunk
    always_ff @(posedge ref_clk_in) begin
      if (reset_in) chunk_r[i] <= CHUNK_RST;
      else if (load_line) chunk_r[i] <= l2_rdata_in[i*64 +: 64]; // RQ13
      else if (wr_chunk && chunk_sel == 2'(i))
        chunk_r[i] <= reg_wdata_in; // RQ13
    end
    assign l2_wdata_out[i*64 +: 64] = chunk_r[i];
  end

  // command, address, state, way and ecc option frozen at the trigger so later
  // writes cannot disturb them; the ecc byte and chunk data go out live
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      l2_cmd_out <= CTL_RST[CMD_LO +: 5];
      l2_addr_out <= ADDR_RST[ADDR_HI:ADDR_LO];
      l2_state_out <= ST_INVALID;
      l2_way_out <= CTL_RST[WAY_TO_LO +: 2];
      l2_user_ecc_out <= 1'b0;
      loads_r <= 1'b0;
    end else if (trig_ok) begin
      l2_cmd_out <= cmd_r; // RQ5 RQ6 RQ7
      l2_addr_out <= addr_r; // RQ1
      l2_state_out <= cmd_state; // RQ8
      l2_way_out <= way_to_r; // RQ9
      l2_user_ecc_out <= user_ecc_r; // RQ10
      loads_r <= cmd_loads; // RQ5 RQ6
    end
  end

  assign l2_req_out = busy; // RQ11
  assign l2_ecc_out = ecc_r; // RQ3

  // read view of each register; reserved bits read zero
  wire [63:0] v_addr = 64'({addr_r, 3'h0});
  wire [63:0] v_ecc = 64'(ecc_r);
  wire [63:0] v_ctl = 64'({user_ecc_r, 1'b0, hit_r, state_from_r,
                           way_from_r, way_to_r, 3'h0, state_to_r, cmd_r});
  wire [63:0] v_busy = 64'(busy) << BUSY_BIT; // RQ12
  wire [63:0] rd_mux = hit_addr ? v_addr :
                       hit_ecc ? v_ecc :
                       hit_ctl ? v_ctl :
                       hit_busy ? v_busy :
                       hit_chunk ? chunk_r[chunk_sel] : 64'h0;

  // read data lives for one cycle only; unmapped reads give zero
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) rdata_r <= 64'h0;
    else rdata_r <= reg_rd_in ? rd_mux : 64'h0;
  end

  assign reg_rdata_out = rdata_r;

  // checks on the block's own behaviour
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence trig_taken;
    trig_ok;
  endsequence

  sequence cmd_done;
    busy ##1 (busy && l2_done_in);
  endsequence

  addr_store_a: assert property ( // RQ1
    wr_addr |=> addr_r == $past(reg_wdata_in[ADDR_HI:ADDR_LO]))
    else $error("address field not stored");

  ecc_reload_a: assert property ( // RQ3
    load_line |=> ecc_r == $past(l2_ecc_in) && l2_ecc_out == ecc_r)
    else $error("ecc not reloaded from cache");

  resp_capture_a: assert property ( // RQ4
    finish |=> state_from_r == $past(l2_state_in) &&
               v_ctl[STATE_FROM_LO +: 2] == state_from_r)
    else $error("response state not captured");

  read_kind_a: assert property ( // RQ5
    trig_ok && lcap_decode(cmd_r) == K_TAG_INQUIRE |=>
      !loads_r && l2_cmd_out == CMD_TAG_INQUIRE)
    else $error("inquire treated as data read");

  int_reg_a: assert property ( // RQ6
    trig_ok && cmd_r == CMD_L2_INTERNAL_REG_READ |=>
      loads_r && l2_req_out)
    else $error("internal register read lost");

  tag_state_a: assert property ( // RQ7
    trig_ok && cmd_r[4:2] == PFX_TAG_ONLY_WRITE |=>
      l2_state_out == $past(cmd_r[1:0]))
    else $error("tag write state not from command");

  state_pass_a: assert property ( // RQ8
    trig_ok && cmd_r == CMD_DATA_READ_LRU_UPDATE |=>
      l2_state_out == $past(state_to_r))
    else $error("state operand not passed");

  way_pass_a: assert property ( // RQ9
    trig_ok |=> l2_way_out == $past(way_to_r) [*1] ##1
      $stable(l2_way_out))
    else $error("way operand unstable");

  hit_report_a: assert property ( // RQ10
    finish |=> hit_r == $past(l2_hit_in) &&
               l2_user_ecc_out == $past(l2_user_ecc_out))
    else $error("hit not reported");

  trig_start_a: assert property ( // RQ11
    trig_taken |=> l2_req_out && l2_addr_out == $past(addr_r))
    else $error("trigger did not start request");

  busy_bit_a: assert property ( // RQ12
    cmd_done |=> !busy && v_busy == 64'h0)
    else $error("busy not cleared after done");

  busy_read_a: assert property ( // RQ12
    reg_rd_in && hit_busy |=> reg_rdata_out == 64'($past(busy)))
    else $error("busy read wrong");

  chunk_load_a: assert property ( // RQ13
    load_line |=> chunk_r[0] == $past(l2_rdata_in[63:0]) &&
                  l2_wdata_out[63:0] == chunk_r[0])
    else $error("chunk not loaded from cache");

  // cache link: request held, operands frozen, clean release
  sequence req_wait;
    l2_req_out && !l2_done_in;
  endsequence

  req_hold_a: assert property ( // RQ11
    req_wait |=> l2_req_out && busy)
    else $error("request dropped before done");

  req_drop_a: assert property ( // RQ12
    finish |=> !l2_req_out && !busy)
    else $error("request held after done");

  ops_frozen_a: assert property ( // RQ4
    l2_req_out |=> $stable(l2_cmd_out) && $stable(l2_addr_out) &&
                   $stable(l2_state_out))
    else $error("operands moved while busy");

  user_ecc_a: assert property ( // RQ10
    trig_ok |=> l2_user_ecc_out == $past(user_ecc_r))
    else $error("user ecc option not passed");

  tag_data_a: assert property ( // RQ7
    trig_ok && lcap_decode(cmd_r) == K_TAG_DATA_WRITE |=>
      !loads_r && l2_state_out == $past(cmd_r[1:0]))
    else $error("tag and data write mishandled");

  int_write_a: assert property ( // RQ6
    trig_ok && cmd_r == CMD_L2_INTERNAL_REG_WRITE |=> !loads_r)
    else $error("internal register write loads data");

  load_kind_a: assert property ( // RQ5
    trig_ok && cmd_r == CMD_TAG_AND_DATA_READ |=> loads_r)
    else $error("tag and data read does not load");

  bad_cmd_a: assert property ( // RQ5
    reg_wr_in && hit_trig && !busy && !cmd_valid |=> !l2_req_out)
    else $error("unknown command issued");

  way_capture_a: assert property ( // RQ9
    finish |=> way_from_r == $past(l2_way_in) && v_ctl[HIT_BIT] == hit_r)
    else $error("returned way not captured");

  // register port: field storage and read view
  ctl_write_a: assert property ( // RQ4
    wr_ctl |=> cmd_r == $past(reg_wdata_in[CMD_LO +: 5]) &&
               way_to_r == $past(reg_wdata_in[WAY_TO_LO +: 2]))
    else $error("control fields not stored");

  ecc_keep_a: assert property ( // RQ3
    finish && !loads_r && !wr_ecc |=> $stable(ecc_r))
    else $error("ecc changed by non-read command");

  chunk_write_a: assert property ( // RQ13
    wr_chunk && !load_line |=>
      chunk_r[$past(chunk_sel)] == $past(reg_wdata_in))
    else $error("chunk write lost");

  addr_view_a: assert property ( // RQ1
    reg_rd_in && hit_addr |=>
      reg_rdata_out[ADDR_LO-1:0] == 3'h0 &&
      reg_rdata_out[63:32] == 32'h0)
    else $error("address reserved bits not zero");

  rdata_idle_a: assert property ( // RQ4
    !reg_rd_in |=> reg_rdata_out == 64'h0)
    else $error("read data outside read cycle");
endmodule
